//--- rtl/motion_data_table_store.sv
// Motion entry table store: working RAM, non-volatile copy and applied copy.
// Assumes a Wishbone classic master and a motion generator on the same clock.

`timescale 1ns/1ps
`default_nettype none

module motion_data_table_store
  import motion_table_pkg::*;
(
  input  wire logic        clk_i,          // 10 MHz system clock.
  input  wire logic        rst_i,          // Synchronous power-up reset.
  input  wire logic        wb_cyc_i,       // Wishbone cycle.
  input  wire logic        wb_stb_i,       // Wishbone strobe.
  input  wire logic        wb_we_i,        // Wishbone write enable.
  input  wire logic [7:0]  wb_adr_i,       // Byte address.
  input  wire logic [3:0]  wb_sel_i,       // Byte lanes.
  input  wire logic [31:0] wb_dat_i,       // Write data.
  output logic      [31:0] wb_dat_o,       // Read data.
  output logic             wb_ack_o,       // Acknowledge.
  input  wire logic        motion_busy_i,  // Motion generator is moving.
  input  wire logic [5:0]  sel_idx_i,      // Entry the generator wants.
  input  wire logic        legacy_push_i,  // Pin strap: earlier revision.
  output var entry_s       entry_o,        // Applied entry at sel_idx_i.
  output logic [ACC_W-1:0] eff_acc_o,      // Acceleration actually used.
  output logic [ACC_W-1:0] eff_dec_o,      // Deceleration actually used.
  output logic             acc_unit_o,     // Applied acceleration unit.
  output logic             tbl_busy_o      // Loading, saving or applying.
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ST_LOAD, ST_IDLE, ST_SAVE, ST_APPLY} st_e;

  typedef struct packed {
    st_e              st;         // Sequencer state.
    logic [IDX_W-1:0] cnt;        // Copy walk counter.
    logic [IDX_W-1:0] idx;        // Entry selected by software.
    logic             ack;        // Bus acknowledge.
    logic [31:0]      rdat;       // Bus read data.
    logic             dirty;      // RAM table differs from applied copy.
    logic             cfg_pend;   // Class C value waits for configure.
    logic             pwr_pend;   // Class D value waits for power-up.
    logic             range_err;  // A write was out of range.
    logic             lim_s1;     // Strap synchroniser, first stage.
    logic             lim_s2;     // Strap synchroniser, second stage.
    glob_s            ram_g;      // Globals as written by software.
    glob_s            app_g;      // Globals in force.
    entry_s           out_e;      // Registered entry to the generator.
    logic [ACC_W-1:0] eff_acc;    // Registered effective acceleration.
    logic [ACC_W-1:0] eff_dec;    // Registered effective deceleration.
    logic             busy;       // Registered busy.
  } state_s;

  state_s s_r;    // Registered state.
  state_s s_nxt;  // Next state.

  // ---------------------------------------------------------------
  // Memories
  // ---------------------------------------------------------------
  // Working RAM: what software reads and writes, lost at power loss.
  entry_s ram_mem [ENTRY_COUNT];
  // Factory contents: every entry at its default. A declaration value, not a
  // process, so that the save walk stays the only writer of storage.
  localparam entry_s ENTRY_DEF = '{POS_DEF, SPD_DEF, MODE_RELATIVE, FUNC_SINGLE,
                                   ACC_DEF, ACC_DEF, PUSH_DEF, 1'h0, DWELL_DEF};
  // Non-volatile copy: never touched by reset, only by the save walk.
  entry_s nvm_mem [ENTRY_COUNT] = '{default: ENTRY_DEF};
  // Applied copy: what the motion generator runs from.
  entry_s act_mem [ENTRY_COUNT];
  // Non-volatile copy of the globals: separate rates, rate per frequency.
  glob_s  nvm_g = '{RATE_SEPARATE, UNIT_PER_KHZ, ACC_DEF, ACC_DEF};

  logic             ram_we;  // RAM write strobe.
  logic [IDX_W-1:0] ram_wa;  // RAM write address.
  entry_s           ram_wd;  // RAM write data.
  logic             nvm_we;  // Storage entry write strobe.
  logic             nvg_we;  // Storage globals write strobe.
  logic             act_we;  // Applied copy write strobe.
  entry_s           ram_idx; // RAM entry at the software index.
  entry_s           ram_cnt; // RAM entry at the walk counter.
  entry_s           nvm_cnt; // Storage entry at the walk counter.
  entry_s           act_sel; // Applied entry at the generator's index.

  assign ram_idx = ram_mem[s_r.idx];
  assign ram_cnt = ram_mem[s_r.cnt];
  assign nvm_cnt = nvm_mem[s_r.cnt];
  assign act_sel = act_mem[sel_idx_i];

  // Memory writes happen on every edge where a strobe is high.
  always_ff @(posedge clk_i) begin
    if (ram_we) begin
      ram_mem[ram_wa] <= ram_wd;
    end
    if (nvm_we) begin
      nvm_mem[s_r.cnt] <= ram_cnt;
    end
    if (nvg_we) begin
      nvm_g <= s_r.ram_g;
    end
    if (act_we) begin
      act_mem[s_r.cnt] <= ram_cnt;
    end
  end

  // ---------------------------------------------------------------
  // Bus decode helpers
  // ---------------------------------------------------------------
  logic        bus_req;   // New request not yet acknowledged.
  logic        bus_wr;    // Full-word write being accepted now.
  logic        wr_open;   // Writes land only outside load and save.
  logic [7:0]  adr;       // Word-aligned byte address.
  logic [31:0] d;         // Write data shorthand.
  logic [31:0] push_lim;  // Push current ceiling in force.
  logic        pos_ok;    // Write data fits a signed 24-bit count.

  assign bus_req  = wb_cyc_i & wb_stb_i & ~s_r.ack;
  assign bus_wr   = bus_req & wb_we_i & (wb_sel_i == 4'hf);
  assign wr_open  = (s_r.st == ST_IDLE) | (s_r.st == ST_APPLY);
  assign adr      = {wb_adr_i[7:2], 2'h0};
  assign d        = wb_dat_i;
  assign push_lim = s_r.lim_s2 ? PUSH_MAX_LEGACY : PUSH_MAX;
  assign pos_ok   = (d[31:23] == 9'h000) | (d[31:23] == 9'h1ff);

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  // One process decides the sequencer, the bus answer and all strobes.
  // Bus handling comes after the sequencer so that a write in the same
  // cycle as a flag clear sets the flag again.
  always_comb begin
    s_nxt     = s_r;
    s_nxt.ack = bus_req;
    ram_we    = 1'b0;
    ram_wa    = s_r.idx;
    ram_wd    = ram_idx;
    nvm_we    = 1'b0;
    nvg_we    = 1'b0;
    act_we    = 1'b0;
    // Only the second stage of the strap synchroniser is read elsewhere.
    s_nxt.lim_s1 = legacy_push_i;
    s_nxt.lim_s2 = s_r.lim_s1;

    unique case (s_r.st)
      // Power-up: storage into RAM, then globals, then an apply walk.
      ST_LOAD: begin
        ram_we = 1'b1;
        ram_wa = s_r.cnt;
        ram_wd = nvm_cnt;
        s_nxt.cnt = s_r.cnt + 6'h01;
        if (s_r.cnt == 6'h3f) begin
          s_nxt.st       = ST_IDLE;
          s_nxt.ram_g    = nvm_g;
          s_nxt.app_g    = nvm_g;  // Class C and D values take effect.
          s_nxt.dirty    = 1'b1;   // Forces the applied copy to refresh.
          s_nxt.cfg_pend = 1'b0;
          s_nxt.pwr_pend = 1'b0;
        end
      end
      // Bulk save walk: RAM into storage, one entry a cycle.
      ST_SAVE: begin
        nvm_we = 1'b1;
        s_nxt.cnt = s_r.cnt + 6'h01;
        if (s_r.cnt == 6'h3f) begin
          s_nxt.st = ST_IDLE;
        end
      end
      // Apply walk: RAM into the applied copy, started only while the motor stands.
      ST_APPLY: begin
        act_we = 1'b1;
        s_nxt.cnt = s_r.cnt + 6'h01;
        if (s_r.cnt == 6'h3f) begin
          s_nxt.st = ST_IDLE;
        end
      end
      // Idle: start an apply walk only once the motor has stopped.
      ST_IDLE: begin
        if (s_r.dirty && !motion_busy_i) begin
          s_nxt.st    = ST_APPLY;
          s_nxt.dirty = 1'b0;
          s_nxt.cnt   = 6'h00;
        end
      end
    endcase

    // Bus writes; during load and save they are acknowledged and dropped.
    if (bus_wr && wr_open) begin
      unique case (adr)
        ADR_CTRL: begin
          if (d[CTRL_CLR_BIT]) begin
            s_nxt.range_err = 1'b0;
          end
          if (d[CTRL_CFG_BIT]) begin
            s_nxt.app_g.rate_type = s_r.ram_g.rate_type;
            s_nxt.cfg_pend        = 1'b0;
          end
          // Save is taken only when idle, so no walk is cut short.
          if (d[CTRL_SAVE_BIT] && s_r.st == ST_IDLE) begin
            s_nxt.st    = ST_SAVE;
            s_nxt.cnt   = 6'h00;
            s_nxt.dirty = s_r.dirty;
            nvg_we      = 1'b1;
          end
        end
        ADR_INDEX: s_nxt.idx = d[IDX_W-1:0];
        ADR_GCFG: begin
          s_nxt.ram_g.rate_type = d[0];
          s_nxt.ram_g.acc_unit  = d[1];
          // Type is class C, unit is class D: only flag them here.
          s_nxt.cfg_pend = s_nxt.cfg_pend | (d[0] != s_r.app_g.rate_type);
          s_nxt.pwr_pend = s_r.pwr_pend | (d[1] != s_r.app_g.acc_unit);
        end
        ADR_CACC, ADR_CDEC: begin
          if (d >= ACC_MIN && d <= ACC_MAX) begin
            // Class A: the value in force changes with the write.
            if (adr == ADR_CACC) begin
              s_nxt.ram_g.cacc = d[ACC_W-1:0];
              s_nxt.app_g.cacc = d[ACC_W-1:0];
            end else begin
              s_nxt.ram_g.cdec = d[ACC_W-1:0];
              s_nxt.app_g.cdec = d[ACC_W-1:0];
            end
          end else begin
            s_nxt.range_err = 1'b1;
          end
        end
        ADR_POS, ADR_SPEED, ADR_MODE, ADR_FUNC, ADR_ACC, ADR_DEC, ADR_PUSH,
        ADR_SEQ, ADR_DWELL: begin
          // Read-modify-write of one field of the selected RAM entry.
          ram_wd = ram_idx;
          unique case (adr)
            ADR_POS:   ram_we = pos_ok;
            ADR_SPEED: ram_we = (d <= SPD_MAX);
            ADR_MODE:  ram_we = (d <= MODE_MAX);
            ADR_FUNC:  ram_we = (d <= FUNC_MAX);
            ADR_ACC:   ram_we = (d >= ACC_MIN) && (d <= ACC_MAX);
            ADR_DEC:   ram_we = (d >= ACC_MIN) && (d <= ACC_MAX);
            ADR_PUSH:  ram_we = (d <= push_lim);
            ADR_SEQ:   ram_we = (d <= FLAG_MAX);
            default:   ram_we = (d <= DWELL_MAX);
          endcase
          unique case (adr)
            ADR_POS:   ram_wd.pos   = d[POS_W-1:0];
            ADR_SPEED: ram_wd.speed = d[SPD_W-1:0];
            ADR_MODE:  ram_wd.mode  = d[0];
            ADR_FUNC:  ram_wd.func  = d[1:0];
            ADR_ACC:   ram_wd.acc   = d[ACC_W-1:0];
            ADR_DEC:   ram_wd.dec   = d[ACC_W-1:0];
            ADR_PUSH:  ram_wd.push  = d[PUSH_W-1:0];
            ADR_SEQ:   ram_wd.seq   = d[0];
            default:   ram_wd.dwell = d[DWELL_W-1:0];
          endcase
          // Any accepted change leaves the applied copy stale.
          s_nxt.dirty     = s_nxt.dirty | ram_we;
          s_nxt.range_err = s_nxt.range_err | ~ram_we;
        end
        default: begin
          // Status and unmapped words ignore writes.
        end
      endcase
    end

    // Read data: unmapped words read as zero.
    unique case (adr)
      ADR_STATUS: s_nxt.rdat = {24'h00_0000, s_r.app_g.acc_unit, s_r.app_g.rate_type,
                                s_r.lim_s2, s_r.range_err, s_r.pwr_pend,
                                s_r.cfg_pend, s_r.dirty, s_r.busy};
      ADR_INDEX:  s_nxt.rdat = {26'h000_0000, s_r.idx};
      ADR_GCFG:   s_nxt.rdat = {30'h0000_0000, s_r.ram_g.acc_unit, s_r.ram_g.rate_type};
      ADR_CACC:   s_nxt.rdat = {12'h000, s_r.ram_g.cacc};
      ADR_CDEC:   s_nxt.rdat = {12'h000, s_r.ram_g.cdec};
      ADR_POS:    s_nxt.rdat = {{8{ram_idx.pos[POS_W-1]}}, ram_idx.pos};
      ADR_SPEED:  s_nxt.rdat = {12'h000, ram_idx.speed};
      ADR_MODE:   s_nxt.rdat = {31'h0000_0000, ram_idx.mode};
      ADR_FUNC:   s_nxt.rdat = {30'h0000_0000, ram_idx.func};
      ADR_ACC:    s_nxt.rdat = {12'h000, ram_idx.acc};
      ADR_DEC:    s_nxt.rdat = {12'h000, ram_idx.dec};
      ADR_PUSH:   s_nxt.rdat = {22'h00_0000, ram_idx.push};
      ADR_SEQ:    s_nxt.rdat = {31'h0000_0000, ram_idx.seq};
      ADR_DWELL:  s_nxt.rdat = {16'h0000, ram_idx.dwell};
      default:    s_nxt.rdat = 32'h0000_0000;
    endcase

    // Entry handed to the generator, with the rates it must really use.
    s_nxt.out_e = act_sel;
    if (s_r.app_g.rate_type == RATE_SEPARATE) begin
      s_nxt.eff_acc = act_sel.acc;
      s_nxt.eff_dec = act_sel.dec;
    end else begin
      s_nxt.eff_acc = s_r.app_g.cacc;
      s_nxt.eff_dec = s_r.app_g.cdec;
    end
    s_nxt.busy = (s_nxt.st != ST_IDLE);
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // Reset is power-up: the sequencer starts with the load walk.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r      <= '0;
      s_r.st   <= ST_LOAD;
      s_r.busy <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wb_dat_o   = s_r.rdat;
  assign wb_ack_o   = s_r.ack;
  assign entry_o    = s_r.out_e;
  assign eff_acc_o  = s_r.eff_acc;
  assign eff_dec_o  = s_r.eff_dec;
  assign acc_unit_o = s_r.app_g.acc_unit;
  assign tbl_busy_o = s_r.busy;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_one_cycle: assert property (bus_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack did not pulse for exactly one cycle");
  a_apply_waits_stop: assert property (
    (s_r.st == ST_IDLE && s_nxt.st == ST_APPLY) |-> !motion_busy_i)
    else $error("apply walk started while the motor moved");
  a_apply_walk_len: assert property (
    (s_r.st == ST_IDLE ##1 s_r.st == ST_APPLY) |-> ##63 s_r.st == ST_APPLY ##1 s_r.st != ST_APPLY)
    else $error("apply walk length is not 64 cycles");
  a_common_acc_now: assert property (
    (bus_wr && wr_open && adr == ADR_CACC && d >= ACC_MIN && d <= ACC_MAX) |=>
      s_r.app_g.cacc == $past(d[ACC_W-1:0]))
    else $error("common acceleration not applied at once");
  a_rate_type_cfg: assert property (
    $changed(s_r.app_g.rate_type) |->
      ($past(s_r.st) == ST_LOAD ||
       $past(bus_wr && wr_open && adr == ADR_CTRL && d[CTRL_CFG_BIT])))
    else $error("rate type changed without configure or power-up");
  a_unit_power_up: assert property (
    $changed(s_r.app_g.acc_unit) |-> $past(s_r.st) == ST_LOAD)
    else $error("unit changed outside power-up");
  a_pos_out_range: assert property (
    (bus_wr && wr_open && adr == ADR_POS && !pos_ok) |=> s_r.range_err && !$past(ram_we))
    else $error("out of range position was accepted");
  a_push_legacy_cap: assert property (
    (bus_wr && wr_open && adr == ADR_PUSH && s_r.lim_s2 && d > PUSH_MAX_LEGACY) |-> !ram_we)
    else $error("push current above 500 accepted on earlier revision");
  a_eff_rate_sel: assert property (
    ($past(s_r.app_g.rate_type) == RATE_COMMON) |-> eff_acc_o == $past(s_r.app_g.cacc))
    else $error("common rate not used when selected");
  a_load_first: assert property (
    $past(rst_i) |-> (s_r.st == ST_LOAD && s_r.cnt == 6'h00) ##64 s_r.st != ST_LOAD)
    else $error("load walk did not run 64 cycles after reset");
  a_save_start: assert property (
    (bus_wr && s_r.st == ST_IDLE && adr == ADR_CTRL && d[CTRL_SAVE_BIT]) |=> s_r.st == ST_SAVE)
    else $error("save command did not start the save walk");

endmodule

`default_nettype wire

//--- rtl/motion_table_pkg.sv
// Shared constants and types for the motion entry table store.
// Assumes one 10 MHz clock domain and a classic Wishbone register bus.

package motion_table_pkg;

  // ---------------------------------------------------------------
  // Table geometry and field widths
  // ---------------------------------------------------------------
  localparam int ENTRY_COUNT = 64;   // Entries 0 to 63.
  localparam int IDX_W       = 6;    // Bits of an entry index.
  localparam int POS_W       = 24;   // Signed step count.
  localparam int SPD_W       = 20;   // Speed in Hz.
  localparam int ACC_W       = 20;   // Acceleration and deceleration.
  localparam int PUSH_W      = 10;   // Push current in 0.1 % units.
  localparam int DWELL_W     = 16;   // Dwell in 1 ms units.

  // ---------------------------------------------------------------
  // Accepted ranges, compared against the 32-bit write data
  // ---------------------------------------------------------------
  localparam logic [31:0] SPD_MAX         = 32'h000f_4240;  // 1,000,000 Hz.
  localparam logic [31:0] ACC_MIN         = 32'h0000_0001;  // 1.
  localparam logic [31:0] ACC_MAX         = 32'h000f_4240;  // 1,000,000.
  localparam logic [31:0] PUSH_MAX        = 32'h0000_03e8;  // 1,000.
  localparam logic [31:0] PUSH_MAX_LEGACY = 32'h0000_01f4;  // 500.
  localparam logic [31:0] DWELL_MAX       = 32'h0000_c350;  // 50,000.
  localparam logic [31:0] MODE_MAX        = 32'h0000_0001;
  localparam logic [31:0] FUNC_MAX        = 32'h0000_0003;
  localparam logic [31:0] FLAG_MAX        = 32'h0000_0001;

  // ---------------------------------------------------------------
  // Factory default values of an entry, held in storage until the first save
  // ---------------------------------------------------------------
  localparam logic [POS_W-1:0]   POS_DEF   = 24'h00_0000;
  localparam logic [SPD_W-1:0]   SPD_DEF   = 20'h0_03e8;   // 1,000.
  localparam logic [ACC_W-1:0]   ACC_DEF   = 20'h0_03e8;   // 1,000.
  localparam logic [PUSH_W-1:0]  PUSH_DEF  = 10'h0c8;      // 200.
  localparam logic [DWELL_W-1:0] DWELL_DEF = 16'h0000;

  // ---------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------
  localparam logic       MODE_RELATIVE     = 1'h0;  // Travel distance.
  localparam logic       MODE_FIXED_TARGET = 1'h1;  // fixed_target_move.
  localparam logic [1:0] FUNC_SINGLE       = 2'h0;
  localparam logic [1:0] FUNC_LINKED       = 2'h1;
  localparam logic [1:0] FUNC_LINKED_DWELL = 2'h2;
  localparam logic [1:0] FUNC_PUSH         = 2'h3;
  localparam logic       RATE_SEPARATE     = 1'h0;  // Per-entry rates.
  localparam logic       RATE_COMMON       = 1'h1;  // Global rates.
  localparam logic       UNIT_PER_KHZ      = 1'h0;  // ms/kHz.
  localparam logic       UNIT_TIME         = 1'h1;  // Seconds.

  // ---------------------------------------------------------------
  // Register byte offsets and control bits
  // ---------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_INDEX  = 8'h08;
  localparam logic [7:0] ADR_GCFG   = 8'h0c;
  localparam logic [7:0] ADR_CACC   = 8'h10;
  localparam logic [7:0] ADR_CDEC   = 8'h14;
  localparam logic [7:0] ADR_POS    = 8'h20;
  localparam logic [7:0] ADR_SPEED  = 8'h24;
  localparam logic [7:0] ADR_MODE   = 8'h28;
  localparam logic [7:0] ADR_FUNC   = 8'h2c;
  localparam logic [7:0] ADR_ACC    = 8'h30;
  localparam logic [7:0] ADR_DEC    = 8'h34;
  localparam logic [7:0] ADR_PUSH   = 8'h38;
  localparam logic [7:0] ADR_SEQ    = 8'h3c;
  localparam logic [7:0] ADR_DWELL  = 8'h40;
  localparam int CTRL_SAVE_BIT = 0;  // Bulk save of RAM into storage.
  localparam int CTRL_CFG_BIT  = 1;  // Configuration command.
  localparam int CTRL_CLR_BIT  = 2;  // Clear the range error flag.

  // One motion entry.
  typedef struct packed {
    logic [POS_W-1:0]   pos;
    logic [SPD_W-1:0]   speed;
    logic               mode;
    logic [1:0]         func;
    logic [ACC_W-1:0]   acc;
    logic [ACC_W-1:0]   dec;
    logic [PUSH_W-1:0]  push;
    logic               seq;
    logic [DWELL_W-1:0] dwell;
  } entry_s;

  // Global rate settings.
  typedef struct packed {
    logic             rate_type;
    logic             acc_unit;
    logic [ACC_W-1:0] cacc;
    logic [ACC_W-1:0] cdec;
  } glob_s;

endpackage

//--- sim/motion_gen.sv
// Motion generator model at the applied-entry port of the table store.
// Assumes the bench commands motion and entry index on the store's clock.
`timescale 1ns/1ps
`default_nettype none
module motion_gen (
  input  wire logic       clk_i,   // Shared clock.
  input  wire logic       go_i,    // Bench asks for motion.
  input  wire logic [5:0] idx_i,   // Entry to run.
  output logic            busy_o,  // High while moving.
  output logic      [5:0] sel_o    // Entry requested.
);
  // Registered, so the store never sees a change in the edge that made it.
  always_ff @(posedge clk_i) begin
    busy_o <= go_i;
    sel_o  <= idx_i;
  end
endmodule
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench: Wishbone master, generator model, queued checks.
// Assumes the package and motion_gen are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import motion_table_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, go = 0, lg = 0, pk = 0, ack, busy, tb, unit;
  logic [7:0] adr = 0;
  logic [5:0] idx = 0, sel;
  logic [31:0] dat = 0, rdo, p, rnd = 32'h0001_7312, q[$];
  logic [ACC_W-1:0] ea, ed;
  entry_s en;
  int n_errors = 0, n_checks = 0, fk = 0, i;
  logic [31:0] dft[8] = '{32'h0, 32'(SPD_DEF), 32'(PUSH_DEF), 32'(ACC_DEF), 32'h0, 32'h0,
                          32'h0, 32'h0};
  logic [7:0] ta[8] = '{ADR_SPEED, ADR_SPEED, ADR_PUSH, ADR_PUSH, ADR_ACC, ADR_DEC,
                        ADR_DWELL, ADR_DWELL};
  logic [31:0] td[8] = '{SPD_MAX + 1, SPD_MAX, 32'h3e9, PUSH_MAX, 32'h0, ACC_MAX,
                         DWELL_MAX + 1, DWELL_MAX};
  logic [31:0] te[8] = '{32'(SPD_DEF), SPD_MAX, 32'(PUSH_DEF), PUSH_MAX, 32'(ACC_DEF), ACC_MAX,
                         32'h0, DWELL_MAX};
  always #50 clk_i = ~clk_i;  // 10 MHz.
  motion_gen i_gen (.clk_i(clk_i), .go_i(go), .idx_i(idx), .busy_o(busy), .sel_o(sel));
  motion_data_table_store i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
    .wb_dat_o(rdo), .wb_ack_o(ack), .motion_busy_i(busy), .sel_idx_i(sel),
    .legacy_push_i(lg), .entry_o(en), .eff_acc_o(ea), .eff_dec_o(ed),
    .acc_unit_o(unit), .tbl_busy_o(tb));
  // Field k of the applied outputs, widened to a bus word.
  function automatic logic [31:0] fv(int k);
    case (k)
      0: return {{8{en.pos[23]}}, en.pos};
      1: return {12'h000, en.speed};
      2: return {22'h0, en.push};
      3: return {12'h000, en.acc};
      4: return {16'h0000, en.dwell};
      5: return {30'h0, en.func};
      6: return {31'h0, en.mode};
      7: return {31'h0, en.seq};
      8: return {12'h000, ea};
      10: return {12'h000, ed};
      default: return {31'h0, unit};
    endcase
  endfunction
  function automatic logic [31:0] nx(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Watcher: each read answer or field probe takes the oldest note.
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0) cmp("read data", q.pop_front(), rdo);
    if (pk) cmp($sformatf("field %0d", fk), q.pop_front(), fv(fk));
  end
  // One classic cycle; the request stands until the edge that sees ack.
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    int t;
    @(posedge clk_i);
    cyc <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    for (t = 0; t < 20 && ack !== 1'b1; t++) @(posedge clk_i);
    cyc <= 0;
    if (t == 20) begin
      n_errors++;
      tally_and_finish();
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic ck(int k, logic [31:0] e);
    q.push_back(e);
    @(posedge clk_i);
    fk <= k;
    pk <= 1;
    @(posedge clk_i);
    pk <= 0;
  endtask
  // Waits out load, save and apply walks, bounded.
  // Two quiet edges in a row: the load walk reaches the apply walk through one idle cycle.
  task automatic idle();
    int lo = 0;
    repeat (4) @(posedge clk_i);
    for (i = 0; i < 500 && lo < 2; i++) begin
      @(posedge clk_i);
      lo = (tb === 1'b0) ? lo + 1 : 0;
    end
    if (lo < 2) begin
      n_errors++;
      tally_and_finish();
    end
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    idx <= 5;
    idle();
    for (i = 0; i < 8; i++) ck(i, dft[i]);
    ck(10, 32'(ACC_DEF));
    $display("test 1 done");
    rnd = nx(rnd);
    p = {{8{rnd[23]}}, rnd[23:0]};
    go <= 1;
    wr(ADR_INDEX, 32'h5);
    wr(ADR_POS, p);
    wr(ADR_MODE, 32'h1);
    wr(ADR_SEQ, 32'h1);
    for (i = 0; i < 4; i++) begin
      wr(ADR_FUNC, i);
      rd(ADR_FUNC, i);
    end
    rd(ADR_POS, p);
    ck(0, 32'h0);
    go <= 0;
    idle();
    ck(0, p);
    ck(6, 32'h1);
    ck(7, 32'h1);
    $display("test 2 done");
    for (i = 0; i < 8; i++) begin
      wr(ta[i], td[i]);
      rd(ta[i], te[i]);
    end
    wr(ADR_POS, 32'h0080_0000);
    rd(ADR_POS, p);
    lg <= 1;
    wr(8'h7c, 32'h1);
    wr(ADR_PUSH, 32'h258);
    rd(ADR_PUSH, PUSH_MAX);
    rd(ADR_CTRL, 32'h0);
    $display("test 3 done");
    wr(ADR_CACC, 32'h7);
    wr(ADR_GCFG, 32'h3);
    idle();
    rd(ADR_STATUS, 32'h3c);
    ck(8, 32'(ACC_DEF));
    ck(10, ACC_MAX);
    wr(ADR_CTRL, 32'h6);
    idle();
    ck(8, 32'h7);
    ck(10, 32'(ACC_DEF));
    ck(9, 32'h0);
    rd(ADR_STATUS, 32'h68);
    wr(ADR_CACC, 32'h9);
    ck(8, 32'h9);
    $display("test 4 done");
    wr(ADR_CTRL, 32'h1);
    idle();
    wr(ADR_POS, 32'h11);
    rst_i <= 1;
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    idle();
    ck(0, p);
    ck(9, 32'h1);
    ck(8, 32'h9);
    rd(ADR_STATUS, 32'he0);
    $display("test 5 done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
